// file: src/ppm_consts.svh
/*
 * Offsets, field positions, reset values and fixed codes for the port
 * power-management and message-interrupt register bank.
 * Assumes inclusion by bare name from the bank's module and the bench.
 */
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
// Function
// - Power state field reports and accepts D0/D3hot
// - D1 and D2 codes treated as reserved
// - Context preserve bit resets to one
// - Sticky event enable gates event messages
// - Hot reset leaves event enable unchanged
// - Status sets on own event, write-one clears
// - Forwarded events never set status
// - Upstream port never sets event status
// - Unimplemented data and bus fields read zero
// - Capability header reads id 0x5, next 0
// - Interrupt enable at bit 16, reset zero
// - Single message enable, capable field zero
// - Wide address capable bit reads one
// - Lower address bits 1:0 read zero
// - Non-zero upper address selects 64-bit write
// - Downstream interrupt writes route upstream
// - Payload low 16 bits, upper read zero

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPM_OFS_PMCTL   8'hc4
`define PPM_OFS_CAPCTL  8'hd0
`define PPM_OFS_ADDRLO  8'hd4
`define PPM_OFS_ADDRHI  8'hd8
`define PPM_OFS_PAYLOAD 8'hdc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPM_PS_LSB      0
`define PPM_CTXP_BIT    3
`define PPM_PMEN_BIT    8
`define PPM_PMST_BIT    15
`define PPM_MSIEN_BIT   16
`define PPM_W64_BIT     23

// ----------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------
`define PPM_PS_D0       2'h0
`define PPM_PS_D3HOT    2'h3
`define PPM_CTXP_RST    1'h1
`define PPM_CAP_ID      8'h05
`define PPM_NEXT_PTR    8'h00
`define PPM_MMSG_ONE    3'h0
`define PPM_MMC_ZERO    3'h0
`define PPM_W64_VAL     1'h1
`define PPM_RESP_OKAY   2'h0
`define PPM_RESP_SLVERR 2'h2
`endif

// file: src/ppm_pkg.sv
/*
 * Types for the port power-management and message-interrupt bank.
 * Assumes nothing beyond the constants header.
 */
package ppm_pkg;
    // Message write sequencer states
    typedef enum logic [1:0] {
        PPM_IDLE = 2'b01,
        PPM_SEND = 2'b10
    } ppm_msg_state_type;
endpackage

// file: src/ppm_bank.sv
/*
 * Port power-management control/status and message-signaled interrupt
 * capability registers, reached over AXI4-Lite, plus the interrupt
 * memory-write request toward the upstream port.
 * Assumes one core clock; event inputs come from same-clock logic.
 * HOT_RESET is a synchronous pulse from the link layer.
 */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ppm_consts.svh"

module ppm_bank #(
    parameter bit IS_UPSTREAM = 1'b0
) (
    // Clock and resets
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        HOT_RESET,
    // AXI4-Lite write address
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // AXI4-Lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Port events
    input  wire logic        PM_EVENT_OWN,
    input  wire logic        PM_EVENT_FWD,
    input  wire logic        INTR_EVENT,
    // Power state and wakeup status
    output logic [1:0]       POWER_STATE,
    output logic             PM_MSG_REQ,
    // Interrupt memory write toward upstream port
    output logic             MSG_VALID,
    input  wire logic        MSG_READY,
    output logic [63:0]      MSG_ADDR,
    output logic             MSG_ADDR64,
    output logic [15:0]      MSG_DATA,
    output logic             MSG_TO_UPSTREAM
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [1:0]  power_state_field_q;
    logic        pm_event_enable_q;
    logic        pm_event_status_q;
    logic        msi_enable_q;
    logic [29:0] lower_address_q;
    logic [31:0] upper_message_address_q;
    logic [15:0] message_payload_field_q;

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_hit;

    assign AWREADY = !aw_held_q && !BVALID;
    assign WREADY  = !w_held_q && !BVALID;
    assign wr_fire = aw_held_q && w_held_q && !BVALID;

    // Capture address and data independently, either order
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= AWADDR;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_held_q <= 1'b1;
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Address decode of the captured write
    always_comb begin
        if (aw_addr_q[7:2] == `PPM_OFS_PMCTL >> 2) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == `PPM_OFS_CAPCTL >> 2) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == `PPM_OFS_ADDRLO >> 2) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == `PPM_OFS_ADDRHI >> 2) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q[7:2] == `PPM_OFS_PAYLOAD >> 2) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            BVALID <= 1'b0;
            BRESP  <= `PPM_RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // One strobe per register for the write that completes this cycle
    logic wr_pm, wr_cap, wr_lo, wr_hi, wr_pay;
    assign wr_pm  = wr_fire && aw_addr_q[7:2] == `PPM_OFS_PMCTL >> 2;
    assign wr_cap = wr_fire && aw_addr_q[7:2] == `PPM_OFS_CAPCTL >> 2;
    assign wr_lo  = wr_fire && aw_addr_q[7:2] == `PPM_OFS_ADDRLO >> 2;
    assign wr_hi  = wr_fire && aw_addr_q[7:2] == `PPM_OFS_ADDRHI >> 2;
    assign wr_pay = wr_fire && aw_addr_q[7:2] == `PPM_OFS_PAYLOAD >> 2;

    // ----------------------------------------------------------------
    // Power management fields
    // ----------------------------------------------------------------
    // Power state: reserved D1/D2 codes are dropped, state kept
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            power_state_field_q <= `PPM_PS_D0;
        end else if (HOT_RESET) begin
            power_state_field_q <= `PPM_PS_D0;
        end else if (wr_pm && w_strb_q[0]) begin
            if (w_data_q[1:0] == `PPM_PS_D0 || w_data_q[1:0] == `PPM_PS_D3HOT) begin
                power_state_field_q <= w_data_q[1:0];
            end
        end
    end

    // Sticky enable: of the two resets only the cold reset RST clears it
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pm_event_enable_q <= 1'b0;
        end else if (wr_pm && w_strb_q[1]) begin
            pm_event_enable_q <= w_data_q[`PPM_PMEN_BIT];
        end
    end

    // Sticky status: own event sets, set beats a write-one clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pm_event_status_q <= 1'b0;
        end else if (PM_EVENT_OWN && !IS_UPSTREAM) begin
            pm_event_status_q <= 1'b1;
        end else if (wr_pm && w_strb_q[1] && w_data_q[`PPM_PMST_BIT]) begin
            pm_event_status_q <= 1'b0;
        end
    end

    // Event message only when enabled; forwarded events not counted
    assign PM_MSG_REQ  = PM_EVENT_OWN && pm_event_enable_q && !IS_UPSTREAM;
    assign POWER_STATE = power_state_field_q;

    // ----------------------------------------------------------------
    // Message interrupt registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            msi_enable_q <= 1'b0;
        end else if (HOT_RESET) begin
            msi_enable_q <= 1'b0;
        end else if (wr_cap && w_strb_q[2]) begin
            msi_enable_q <= w_data_q[`PPM_MSIEN_BIT];
        end
    end

    // Address and payload, byte lanes honoured
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            lower_address_q         <= 30'h0000_0000;
            upper_message_address_q <= 32'h0000_0000;
            message_payload_field_q <= 16'h0000;
        end else if (HOT_RESET) begin
            lower_address_q         <= 30'h0000_0000;
            upper_message_address_q <= 32'h0000_0000;
            message_payload_field_q <= 16'h0000;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (wr_hi && w_strb_q[b]) begin
                    upper_message_address_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
                end
            end
            if (wr_lo && w_strb_q[0]) begin
                lower_address_q[5:0] <= w_data_q[7:2];
            end
            if (wr_lo && w_strb_q[1]) begin
                lower_address_q[13:6] <= w_data_q[15:8];
            end
            if (wr_lo && w_strb_q[2]) begin
                lower_address_q[21:14] <= w_data_q[23:16];
            end
            if (wr_lo && w_strb_q[3]) begin
                lower_address_q[29:22] <= w_data_q[31:24];
            end
            if (wr_pay && w_strb_q[0]) begin
                message_payload_field_q[7:0] <= w_data_q[7:0];
            end
            if (wr_pay && w_strb_q[1]) begin
                message_payload_field_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_hit;

    assign ARREADY = !RVALID;

    // Read mux; unimplemented and reserved bits are zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (ARADDR[7:2] == `PPM_OFS_PMCTL >> 2) begin
            rd_word[1:0]           = power_state_field_q;
            rd_word[`PPM_CTXP_BIT] = `PPM_CTXP_RST; // no loader path, so fixed
            rd_word[`PPM_PMEN_BIT] = pm_event_enable_q;
            rd_word[`PPM_PMST_BIT] = pm_event_status_q; // others zero
        end else if (ARADDR[7:2] == `PPM_OFS_CAPCTL >> 2) begin
            rd_word[7:0]            = `PPM_CAP_ID;
            rd_word[15:8]           = `PPM_NEXT_PTR;
            rd_word[`PPM_MSIEN_BIT] = msi_enable_q;
            rd_word[19:17]          = `PPM_MMC_ZERO;
            rd_word[22:20]          = `PPM_MMSG_ONE;
            rd_word[`PPM_W64_BIT]   = `PPM_W64_VAL;
        end else if (ARADDR[7:2] == `PPM_OFS_ADDRLO >> 2) begin
            rd_word = {lower_address_q, 2'b00};
        end else if (ARADDR[7:2] == `PPM_OFS_ADDRHI >> 2) begin
            rd_word = upper_message_address_q;
        end else if (ARADDR[7:2] == `PPM_OFS_PAYLOAD >> 2) begin
            rd_word = {16'h0000, message_payload_field_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read data registered, one cycle after address taken
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0000_0000;
            RRESP  <= `PPM_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA  <= rd_word;
            RRESP  <= rd_hit ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt memory write sequencer
    // ----------------------------------------------------------------
    ppm_pkg::ppm_msg_state_type msg_state_q;

    // An event while a write is pending is merged into it
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            msg_state_q <= ppm_pkg::PPM_IDLE;
            MSG_ADDR    <= 64'h0;
            MSG_ADDR64  <= 1'b0;
            MSG_DATA    <= 16'h0000;
        end else begin
            case (msg_state_q)
                ppm_pkg::PPM_IDLE: begin
                    if (INTR_EVENT && msi_enable_q) begin
                        msg_state_q <= ppm_pkg::PPM_SEND;
                        MSG_ADDR    <= {upper_message_address_q, lower_address_q, 2'b00};
                        MSG_ADDR64  <= upper_message_address_q != 32'h0;
                        MSG_DATA    <= message_payload_field_q;
                    end
                end
                ppm_pkg::PPM_SEND: begin
                    if (MSG_READY) begin
                        msg_state_q <= ppm_pkg::PPM_IDLE;
                    end
                end
                default: begin
                    msg_state_q <= ppm_pkg::PPM_IDLE;
                end
            endcase
        end
    end

    assign MSG_VALID       = msg_state_q == ppm_pkg::PPM_SEND;
    assign MSG_TO_UPSTREAM = !IS_UPSTREAM; // relies on

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence own_event_s;
        PM_EVENT_OWN && !IS_UPSTREAM;
    endsequence

    status_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
        own_event_s |=> pm_event_status_q)
        else $error("event status not set after own event");

    fwd_only_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (PM_EVENT_FWD && !PM_EVENT_OWN && !pm_event_status_q) |=> !pm_event_status_q)
        else $error("forwarded event set status");

    upstream_status_a: assert property (@(posedge REF_CLK) disable iff (RST)
        IS_UPSTREAM |-> !pm_event_status_q)
        else $error("upstream status set");

    hot_keep_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (HOT_RESET && !wr_pm) |=> $stable(pm_event_enable_q))
        else $error("hot reset changed enable");

    state_legal_a: assert property (@(posedge REF_CLK) disable iff (RST)
        power_state_field_q == `PPM_PS_D0 || power_state_field_q == `PPM_PS_D3HOT)
        else $error("reserved power state held");

    msg_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $rose(MSG_VALID) |-> $past(msi_enable_q) && $past(INTR_EVENT))
        else $error("message write without enable and event");

    addr_wide_a: assert property (@(posedge REF_CLK) disable iff (RST)
        MSG_VALID |-> MSG_ADDR64 == (MSG_ADDR[63:32] != 32'h0))
        else $error("address width select wrong");

    msg_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (MSG_VALID && !MSG_READY) |=> MSG_VALID && $stable(MSG_ADDR) && $stable(MSG_DATA))
        else $error("message write dropped before taken");

    pm_msg_a: assert property (@(posedge REF_CLK) disable iff (RST)
        PM_MSG_REQ |-> pm_event_enable_q)
        else $error("event message while disabled");

endmodule

// file: tb/ppm_upstream_model.sv
/*
 * Upstream routing partner that accepts the interrupt memory write.
 * Assumes the request and its payload hold until accepted at a rising edge.
 */
`timescale 1ns/1ns

module ppm_upstream_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Interrupt write request from the port
    input  wire logic        msg_valid,
    input  wire logic [63:0] msg_addr,
    input  wire logic        msg_addr64,
    input  wire logic [15:0] msg_data,
    output logic             msg_ready,
    // Record of the last accepted write
    output logic [63:0]      got_addr_q,
    output logic             got_addr64_q,
    output logic [15:0]      got_data_q,
    output logic [7:0]       got_count_q
);
    logic [1:0] wait_q;

    // Even-numbered writes wait three cycles, odd ones pass at once,
    // so the port sees both a slow and a prompt partner
    assign msg_ready = msg_valid && (got_count_q[0] || wait_q == 2'h3);

    // Stall counter and record of each accepted write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q       <= 2'h0;
            got_addr_q   <= 64'h0;
            got_addr64_q <= 1'b0;
            got_data_q   <= 16'h0;
            got_count_q  <= 8'h0;
        end else if (msg_ready) begin
            wait_q       <= 2'h0;
            got_addr_q   <= msg_addr;
            got_addr64_q <= msg_addr64;
            got_data_q   <= msg_data;
            got_count_q  <= got_count_q + 8'h1;
        end else if (msg_valid) begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule

// file: tb/tb_top.sv
/*
 * Self-checking bench for the port power-management and interrupt bank.
 * Assumes the bank's AXI4-Lite timing and the upstream partner beside it.
 */
`timescale 1ns/1ns
`include "ppm_consts.svh"

module tb_top;
    // Stimulus, valued from time zero
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic [3:0]  evt = 4'h0;  // Hot reset, interrupt, forwarded, own
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    // Observed outputs
    logic        awready, wready, bvalid, arready, rvalid, pm_msg_req, req_seen;
    logic        msg_valid, msg_ready, msg_addr64, msg_to_upstream, got_addr64;
    logic [1:0]  bresp, rresp, power_state;
    logic [31:0] rdata, up_rdata;
    logic [63:0] msg_addr, got_addr;
    logic [15:0] msg_data, got_data;
    logic [7:0]  got_count;
    int          bad_count = 0, num_checks = 0;
    // Interrupt registers, their reset values and what survives all-ones
    logic [7:0]  ofs [4] = '{`PPM_OFS_CAPCTL, `PPM_OFS_ADDRLO, `PPM_OFS_ADDRHI,
                             `PPM_OFS_PAYLOAD};
    logic [31:0] rst_val [4] = '{32'h0080_0005, 32'h0, 32'h0, 32'h0};
    logic [31:0] kept [4] = '{32'h0081_0005, 32'hffff_fffc, 32'hffff_ffff, 32'h0000_ffff};

    // Bank as a downstream port
    ppm_bank #(.IS_UPSTREAM(1'b0)) ppm_bank_i (
        .REF_CLK(ref_clk), .RST(rst), .HOT_RESET(evt[3]),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .PM_EVENT_OWN(evt[0]), .PM_EVENT_FWD(evt[1]), .INTR_EVENT(evt[2]),
        .POWER_STATE(power_state), .PM_MSG_REQ(pm_msg_req),
        .MSG_VALID(msg_valid), .MSG_READY(msg_ready), .MSG_ADDR(msg_addr),
        .MSG_ADDR64(msg_addr64), .MSG_DATA(msg_data), .MSG_TO_UPSTREAM(msg_to_upstream)
    );

    // Upstream routing partner
    ppm_upstream_model ppm_upstream_model_i (
        .clk(ref_clk), .rst(rst), .msg_valid(msg_valid), .msg_addr(msg_addr),
        .msg_addr64(msg_addr64), .msg_data(msg_data), .msg_ready(msg_ready),
        .got_addr_q(got_addr), .got_addr64_q(got_addr64), .got_data_q(got_data),
        .got_count_q(got_count)
    );

    // Same bank as the upstream port, sharing every AXI4-Lite and event input
    ppm_bank #(.IS_UPSTREAM(1'b1)) ppm_bank_up_i (
        .REF_CLK(ref_clk), .RST(rst), .HOT_RESET(evt[3]),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(),
        .BRESP(), .BVALID(), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(),
        .RDATA(up_rdata), .RRESP(), .RVALID(), .RREADY(rready),
        .PM_EVENT_OWN(evt[0]), .PM_EVENT_FWD(evt[1]), .INTR_EVENT(evt[2]),
        .POWER_STATE(), .PM_MSG_REQ(),
        .MSG_VALID(), .MSG_READY(1'b1), .MSG_ADDR(),
        .MSG_ADDR64(), .MSG_DATA(), .MSG_TO_UPSTREAM()
    );

    // Core clock, 40 ns period
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Compare and count; case inequality so an unknown never matches
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One AXI4-Lite access; handshakes sampled at the falling edge before
    // the rising edge that takes them, which keeps clear of update races
    task automatic axi(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tr, done;
        int   n;
        done = 1'b0;
        n = 0;
        @(posedge ref_clk);
        if (is_wr) begin
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end else begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        while (!done && n < 100) begin
            @(negedge ref_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            done = is_wr ? (bvalid && bready) : (rvalid && rready);
            if (done) begin
                check(is_wr ? bresp : rresp, er);
                if (!is_wr) check(rdata, d);
            end
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
            n++;
        end
        if (!done) begin
            bad_count++;
            stop_test();
        end
    endtask

    // Full-word access expecting an okay response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi(1'b1, a, d, 4'hf, `PPM_RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        axi(1'b0, a, e, 4'h0, `PPM_RESP_OKAY);
    endtask

    // One-cycle event pulse; the message request is caught mid-pulse
    task automatic pulse(input logic [3:0] e);
        @(posedge ref_clk);
        evt <= e;
        @(negedge ref_clk);
        req_seen = pm_msg_req;
        @(posedge ref_clk);
        evt <= 4'h0;
    endtask

    // All five registers against their reset values
    task automatic rd_all(input logic [31:0] pm);
        rd(`PPM_OFS_PMCTL, pm);
        for (int i = 0; i < 4; i++) begin
            rd(ofs[i], rst_val[i]);
        end
    endtask

    // Raise an interrupt event and see whether a write reaches upstream
    task automatic send(input logic exp);
        logic [7:0] c;
        c = got_count;
        pulse(4'h4);
        for (int n = 0; n < 20 && got_count == c; n++) begin
            @(negedge ref_clk);
        end
        check(got_count != c, exp);
    endtask

    // Power state codes, reserved codes and a strobe that misses the field
    task automatic t_power;
        wr(`PPM_OFS_PMCTL, 32'h0000_0003);
        check(power_state, `PPM_PS_D3HOT);
        wr(`PPM_OFS_PMCTL, 32'h0000_0001);
        wr(`PPM_OFS_PMCTL, 32'h0000_0002);
        axi(1'b1, `PPM_OFS_PMCTL, 32'h0, 4'he, `PPM_RESP_OKAY);
        rd(`PPM_OFS_PMCTL, 32'h0000_000b);
        wr(`PPM_OFS_PMCTL, 32'h0000_0000);
        check(power_state, `PPM_PS_D0);
    endtask

    // Event enable, sticky status, forwarded events and hot reset
    task automatic t_pm;
        wr(`PPM_OFS_PMCTL, 32'hffff_ffff);
        rd(`PPM_OFS_PMCTL, 32'h0000_010b);
        pulse(4'h2);
        check(req_seen, 1'b0);
        rd(`PPM_OFS_PMCTL, 32'h0000_010b);
        pulse(4'h1);
        check(req_seen, 1'b1);
        pulse(4'h8);
        rd(`PPM_OFS_PMCTL, 32'h0000_8108);
        check(up_rdata, 32'h0000_0108);
        wr(`PPM_OFS_PMCTL, 32'h0000_8000);
        pulse(4'h1);
        check(req_seen, 1'b0);
        rd(`PPM_OFS_PMCTL, 32'h0000_8008);
        wr(`PPM_OFS_PMCTL, 32'h0000_8000);
        rd(`PPM_OFS_PMCTL, 32'h0000_0008);
    endtask

    // Interrupt registers written all-ones, then cleared by hot reset
    task automatic t_msi_regs;
        for (int i = 0; i < 4; i++) begin
            wr(ofs[i], 32'hffff_ffff);
            rd(ofs[i], kept[i]);
        end
        pulse(4'h8);
        rd_all(32'h0000_0008);
    endtask

    // Unmapped place: error response and no effect
    task automatic t_unmapped;
        axi(1'b0, 8'hc8, 32'h0, 4'h0, `PPM_RESP_SLVERR);
        axi(1'b1, 8'hc8, 32'hffff_ffff, 4'hf, `PPM_RESP_SLVERR);
        rd(`PPM_OFS_PMCTL, 32'h0000_0008);
    endtask

    // Interrupt writes: disabled, then 32-bit slow, then 64-bit prompt
    task automatic t_msi_send;
        wr(`PPM_OFS_ADDRLO, 32'h0000_1000);
        wr(`PPM_OFS_PAYLOAD, 32'h1234_abcd);
        send(1'b0);
        wr(`PPM_OFS_CAPCTL, 32'h0001_0000);
        send(1'b1);
        check(got_addr, 64'h0000_0000_0000_1000);
        check({got_addr64, got_data}, {1'b0, 16'habcd});
        check(msg_to_upstream, 1'b1);
        wr(`PPM_OFS_ADDRHI, 32'h0000_0002);
        send(1'b1);
        check(got_addr, 64'h0000_0002_0000_1000);
        check(got_addr64, 1'b1);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd_all(32'h0000_0008);
        check(power_state, `PPM_PS_D0);
        t_power;
        t_pm;
        t_msi_regs;
        t_unmapped;
        t_msi_send;
        stop_test();
    end
endmodule
